// ---- hw/cmb_msg_store.sv ----
// can message buffer store: tx buffers, arbitration, abort, rx fifo, ahb regs
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_store #(
  parameter int RX_DEPTH = cmb_pkg::RX_DEPTH
) (
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  // ahb-lite slave
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic      [31:0]                    hrdata,
  output logic                                hresp,
  // transmit side
  input  wire logic                           arb_req,
  output logic                                tx_grant_valid,
  output logic      [1:0]                     tx_grant_index,
  input  wire logic [1:0]                     tx_word_addr,
  output logic      [31:0]                    tx_word_data,
  input  wire logic                           tx_done,
  input  wire logic                           tx_error,
  input  wire logic                           tx_lost,
  input  wire logic [15:0]                    tx_stamp,
  // receive side
  input  wire logic                           rx_wr_valid,
  input  wire logic [1:0]                     rx_wr_addr,
  input  wire logic [31:0]                    rx_wr_data,
  input  wire logic                           rx_commit,
  output logic                                rx_ack_allow,
  // interrupt levels
  output logic                                tx_irq,
  output logic                                rx_irq,
  output logic                                err_irq
);
  import cmb_pkg::*;

  // push and pop must overlap in one fifo
  if (RX_DEPTH < 2) begin : g_chk
    $error("cmb_msg_store: receive fifo needs at least 2 stages");
  end

  // two index bits serve four buffers at most
  if (NUM_TX > 4) begin : g_tx_chk
    $error("cmb_msg_store: grant index too narrow");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    // control fields
    logic                                     loop;
    logic [NUM_TX-1:0]                        txie;
    logic                                     rxie;
    logic                                     ovrie;
    // transmit flags, receive overrun flag and transmit buffers
    logic [NUM_TX-1:0]                        txe;
    logic [NUM_TX-1:0]                        sel;
    logic [NUM_TX-1:0]                        abort_request_bit;
    logic [NUM_TX-1:0]                        abort_acknowledge_flag;
    logic                                     ovr;
    logic [NUM_TX-1:0][WIN_WORDS-1:0][31:0]   txbuf;
    // grant and bus pipe
    logic                                     active;
    logic [1:0]                               idx;
    logic [31:0]                              tx_word;
    logic                                     dph_wr;
    logic [ADDR_W-1:0]                        dph_addr;
    logic [31:0]                              rdata;
  } cmb_state_t;

  // registered state and next value
  cmb_state_t                 s_reg;
  cmb_state_t                 s_next;

  // bus and fifo strobes
  logic                       take;
  logic                       pop;
  logic                       push;

  // fifo status
  logic                       rx_empty;
  logic                       rx_full;
  logic                       rx_ovr;
  logic [WIN_WORDS*32-1:0]    fg_data;

  // transmit selection
  logic [1:0]                 sel_idx;
  logic [1:0]                 best;
  logic [ADDR_W-1:0]          a_addr;

  // ************************************************************
  // helpers
  // ************************************************************
  // lowest set bit only, so a multi-bit select write picks one buffer
  function automatic logic [NUM_TX-1:0] first_one(input logic [NUM_TX-1:0] v);
    first_one = v & (~v + 1'b1);
  endfunction

  // index of a one-hot select, zero when none
  function automatic logic [1:0] onehot_idx(input logic [NUM_TX-1:0] v);
    onehot_idx = 2'h0;
    for (int i = NUM_TX - 1; i >= 0; i--) begin
      if (v[i]) begin
        onehot_idx = 2'(i);
      end
    end
  endfunction

  // strict less keeps the lower index on a priority tie
  function automatic logic [1:0] pick_best(input logic [NUM_TX-1:0] pend,
                                           input cmb_state_t st);
    logic [7:0] bp;
    logic       found;
    pick_best = 2'h0;
    bp        = 8'hFF;
    found     = 1'b0;
    for (int i = 0; i < NUM_TX; i++) begin
      if (pend[i] && (!found || st.txbuf[i][LAST_WORD][W3_LOCAL_PRIORITY_LSB +: 8] < bp)) begin
        pick_best = 2'(i);
        bp        = st.txbuf[i][LAST_WORD][W3_LOCAL_PRIORITY_LSB +: 8];
        found     = 1'b1;
      end
    end
  endfunction

  // decoded select and arbitration winner
  assign sel_idx = onehot_idx(s_reg.sel);
  assign best    = pick_best(~s_reg.txe, s_reg);
  assign a_addr  = {haddr[ADDR_W-1:2], 2'b00};

  // ************************************************************
  // next state: bus writes first, hardware events after so sets win
  // ************************************************************
  always_comb begin
    s_next = s_reg;
    pop    = 1'b0;
    push   = 1'b0;
    take   = hsel && hready && htrans[HTRANS_ACT];

    // address phase: latch for a write, prepare read data now
    s_next.dph_wr   = take && hwrite;
    s_next.dph_addr = a_addr;
    if (take && !hwrite) begin
      s_next.rdata = ZERO_WORD;  // unmapped offsets read zero
      // windows first, then the flat map
      if (a_addr[7:4] == OFS_TXWIN) begin
        if ((s_reg.sel & s_reg.txe) != TX_NONE) begin
          s_next.rdata = s_reg.txbuf[sel_idx][a_addr[3:2]];
        end
      end else if (a_addr[7:4] == OFS_RXWIN) begin
        if (!rx_empty) begin
          s_next.rdata = fg_data[a_addr[3:2]*32 +: 32];
        end
      end else begin
        // control and flag registers
        unique case (a_addr)
          OFS_CTRL: begin
            s_next.rdata[CTRL_LOOP_BIT]                 = s_reg.loop;
            s_next.rdata[CTRL_TXIE_LSB +: NUM_TX]       = s_reg.txie;
            s_next.rdata[CTRL_RXIE_BIT]                 = s_reg.rxie;
            s_next.rdata[CTRL_OVRIE_BIT]                = s_reg.ovrie;
          end
          OFS_TXFLG: s_next.rdata[NUM_TX-1:0] = s_reg.txe;
          OFS_TXSEL: s_next.rdata[NUM_TX-1:0] = s_reg.sel;
          OFS_ABORT_REQUEST_BIT: s_next.rdata[NUM_TX-1:0] = s_reg.abort_request_bit;
          OFS_ABORT_ACKNOWLEDGE_FLAG: s_next.rdata[NUM_TX-1:0] = s_reg.abort_acknowledge_flag;
          OFS_RXFLG: begin
            s_next.rdata[RXFLG_RXF_BIT] = !rx_empty;
            s_next.rdata[RXFLG_OVR_BIT] = s_reg.ovr;
          end
          default: s_next.rdata = ZERO_WORD;
        endcase
      end
    end

    // data phase of a write
    if (s_reg.dph_wr) begin
      if (s_reg.dph_addr[7:4] == OFS_TXWIN) begin
        // loading only while the selected buffer is still empty
        if ((s_reg.sel & s_reg.txe) != TX_NONE) begin
          if (s_reg.dph_addr[3:2] == LAST_WORD) begin
            // stamp half stays controller owned
            s_next.txbuf[sel_idx][LAST_WORD] =
              (hwdata & ~STAMP_MASK) | (s_reg.txbuf[sel_idx][LAST_WORD] & STAMP_MASK);
          end else begin
            s_next.txbuf[sel_idx][s_reg.dph_addr[3:2]] = hwdata;
          end
        end
      end else begin
        // control and flag registers
        unique case (s_reg.dph_addr)
          OFS_CTRL: begin
            s_next.loop  = hwdata[CTRL_LOOP_BIT];
            s_next.txie  = hwdata[CTRL_TXIE_LSB +: NUM_TX];
            s_next.rxie  = hwdata[CTRL_RXIE_BIT];
            s_next.ovrie = hwdata[CTRL_OVRIE_BIT];
          end
          OFS_TXFLG: begin
            // writing one schedules the buffer and drops the old ack
            s_next.txe   = s_reg.txe & ~hwdata[NUM_TX-1:0];
            s_next.abort_acknowledge_flag = s_reg.abort_acknowledge_flag & ~(hwdata[NUM_TX-1:0] & s_reg.txe);
          end
          // select lands on an empty buffer only
          OFS_TXSEL: s_next.sel = first_one(hwdata[NUM_TX-1:0] & s_reg.txe);
          OFS_ABORT_REQUEST_BIT: s_next.abort_request_bit = s_reg.abort_request_bit | (hwdata[NUM_TX-1:0] & ~s_reg.txe);
          OFS_RXFLG: begin
            pop = hwdata[RXFLG_RXF_BIT] && !rx_empty;
            if (hwdata[RXFLG_OVR_BIT]) begin
              s_next.ovr = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end

    // abort grant for pending buffers not on the wire
    for (int i = 0; i < NUM_TX; i++) begin
      if (s_reg.abort_request_bit[i] && !s_reg.txe[i] && !(s_reg.active && s_reg.idx == 2'(i))) begin
        s_next.txe[i]   = 1'b1;
        s_next.abort_acknowledge_flag[i] = 1'b1;
      end
    end

    // arbitration point before start of frame, rerun every time
    if (arb_req && !s_reg.active && (~s_reg.txe != TX_NONE)) begin
      s_next.active = 1'b1;
      s_next.idx    = best;
    end

    // end of a transmission
    if (s_reg.active && tx_done) begin
      s_next.txe[s_reg.idx]   = 1'b1;
      s_next.abort_acknowledge_flag[s_reg.idx] = 1'b0;
      // stamp only for frames that went out
      s_next.txbuf[s_reg.idx][LAST_WORD][W3_STAMP_LSB +: 16] = tx_stamp;
      s_next.active           = 1'b0;
    end else if (s_reg.active && (tx_error || tx_lost)) begin
      // buffer stays pending and competes again at the next arbitration
      s_next.active = 1'b0;
    end

    // a released buffer keeps no stale abort request
    s_next.abort_request_bit = s_next.abort_request_bit & ~s_next.txe;

    // frame data toward the bit engine, one word per request
    s_next.tx_word = s_reg.txbuf[s_reg.idx][tx_word_addr];

    // receive: own frames only go in under loopback
    push = rx_commit && (s_reg.loop || !s_reg.active);

    // dropped frame; set beats a host clear
    if (rx_ovr) begin
      s_next.ovr = 1'b1;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg     <= '0;
      s_reg.txe <= TXE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // receive fifo
  // ************************************************************
  // background writes go on even while full, transmit is untouched
  cmb_rx_fifo #(
    .DEPTH (RX_DEPTH),
    .WORDS (WIN_WORDS)
  ) u_rx_fifo (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .bg_wr_valid (rx_wr_valid),
    .bg_wr_addr  (rx_wr_addr),
    .bg_wr_data  (rx_wr_data),
    .push        (push),
    .pop         (pop),
    .fg_data     (fg_data),
    .empty       (rx_empty),
    .full        (rx_full),
    .overrun     (rx_ovr)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  // bus slave never stalls
  assign hreadyout      = 1'b1;  // zero wait states
  assign hresp          = 1'b0;  // always okay
  assign hrdata         = s_reg.rdata;

  // grant and frame words
  assign tx_grant_valid = s_reg.active;
  assign tx_grant_index = s_reg.idx;
  assign tx_word_data   = s_reg.tx_word;

  // no ack for own frames unless loopback is on
  assign rx_ack_allow   = s_reg.loop || !s_reg.active;

  // request levels for the system interrupt controller
  assign tx_irq         = |(s_reg.txe & s_reg.txie);
  assign rx_irq         = s_reg.rxie && !rx_empty;
  assign err_irq        = s_reg.ovrie && s_reg.ovr && !rx_full ? 1'b1 :
                          (s_reg.ovrie && s_reg.ovr);
endmodule
`default_nettype wire

// ---- hw/cmb_pkg.sv ----
// constants shared by the message buffer store and its receive fifo
package cmb_pkg;
  // ************************************************************
  // structure sizes
  // ************************************************************
  localparam int NUM_TX    = 3;   // transmit buffers
  localparam int WIN_WORDS = 4;   // words per buffer window
  localparam int RX_DEPTH  = 5;   // receive fifo stages
  localparam int ADDR_W    = 8;   // decoded address bits

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_TXFLG = 8'h04;
  localparam logic [7:0] OFS_TXSEL = 8'h08;
  localparam logic [7:0] OFS_ABORT_REQUEST_BIT = 8'h0C;
  localparam logic [7:0] OFS_ABORT_ACKNOWLEDGE_FLAG = 8'h10;
  localparam logic [7:0] OFS_RXFLG = 8'h14;
  localparam logic [3:0] OFS_TXWIN = 4'h2;  // upper nibble, 0x20..0x2C
  localparam logic [3:0] OFS_RXWIN = 4'h3;  // upper nibble, 0x30..0x3C

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int CTRL_LOOP_BIT  = 0;
  localparam int CTRL_TXIE_LSB  = 1;
  localparam int CTRL_RXIE_BIT  = 4;
  localparam int CTRL_OVRIE_BIT = 5;
  localparam int RXFLG_RXF_BIT  = 0;
  localparam int RXFLG_OVR_BIT  = 1;
  localparam int W3_DLC_LSB     = 0;   // last window word: length code
  localparam int W3_LOCAL_PRIORITY_LSB    = 8;   // last window word: local priority
  localparam int W3_STAMP_LSB   = 16;  // last window word: time stamp
  localparam logic [1:0]  LAST_WORD    = 2'h3;
  localparam logic [31:0] STAMP_MASK   = 32'hFFFF0000;
  localparam logic [2:0]  TXE_RESET    = 3'h7;
  localparam logic [2:0]  TX_NONE      = 3'h0;
  localparam logic [31:0] ZERO_WORD    = 32'h00000000;
  localparam int          HTRANS_ACT   = 1;  // htrans[1] marks nonseq/seq
endpackage

// ---- hw/cmb_rx_fifo.sv ----
// receive fifo with one background buffer and a foreground head entry
`timescale 1ns/1ps
`default_nettype none
module cmb_rx_fifo #(
  parameter int DEPTH = 5,
  parameter int WORDS = 4
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       bg_wr_valid,
  input  wire logic [$clog2(WORDS)-1:0]   bg_wr_addr,
  input  wire logic [31:0]                bg_wr_data,
  input  wire logic                       push,
  input  wire logic                       pop,
  output logic      [WORDS*32-1:0]        fg_data,
  output logic                            empty,
  output logic                            full,
  output logic                            overrun
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  if (DEPTH < 2 || WORDS < 2) begin : g_chk
    $error("cmb_rx_fifo: depth and words must be at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WORDS*32-1:0] mem;
    logic [WORDS-1:0][31:0]         bg;
    logic [PW-1:0]                  wptr;
    logic [PW-1:0]                  rptr;
    logic [CW-1:0]                  count;
  } cmb_fifo_t;

  cmb_fifo_t s_reg;
  cmb_fifo_t s_next;
  logic      do_push;
  logic      do_pop;

  // pointer advance with wrap at the last stage
  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PTR_LAST) ? '0 : PW'(p + 1'b1);
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_next  = s_reg;
    do_pop  = pop && (s_reg.count != '0);
    // a stage freed this cycle is usable by a push in the same cycle
    do_push = push && ((s_reg.count != CNT_FULL) || do_pop);
    if (bg_wr_valid) begin
      s_next.bg[bg_wr_addr] = bg_wr_data;  // bad frames simply get overwritten
    end
    if (do_push) begin
      s_next.mem[s_reg.wptr] = s_reg.bg;
      s_next.wptr            = next_ptr(s_reg.wptr);
    end
    if (do_pop) begin
      s_next.rptr = next_ptr(s_reg.rptr);
    end
    if (do_push && !do_pop) begin
      s_next.count = CW'(s_reg.count + 1'b1);
    end else if (do_pop && !do_push) begin
      s_next.count = CW'(s_reg.count - 1'b1);
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // head entry and status
  assign fg_data = s_reg.mem[s_reg.rptr];
  assign empty   = (s_reg.count == '0);
  assign full    = (s_reg.count == CNT_FULL);
  assign overrun = push && !do_push;  // accepted frame but no stage free
endmodule
`default_nettype wire

// ---- test/can_message_buffer_store_tb.sv ----
// self-checking bench: ahb host and bus side model around the store
`timescale 1ns/1ps
`default_nettype none
module can_message_buffer_store_tb;
  import cmb_pkg::*;
  localparam logic [15:0] STAMP = 16'hC3A5;
  logic        hclk = 1'b0, hresetn = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [1:0]  htrans = 2'h0, tx_grant_index, tx_word_addr, rx_wr_addr;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, tx_word_data, rx_wr_data, rd;
  logic        hreadyout, hresp, arb_req, tx_grant_valid, tx_done, tx_error, tx_lost;
  logic        rx_wr_valid, rx_commit, rx_ack_allow, tx_irq, rx_irq, err_irq;
  logic [15:0] tx_stamp;
  int          err_count = 0, samples_checked = 0;
  assign hready = hreadyout;
  cmb_msg_store u_cmb_msg_store (.*);
  cmb_can_node #(.STAMP(STAMP)) u_cmb_can_node (.*);
  // 50 MHz clock
  always #10 hclk = ~hclk;
  // ************************************************************
  // bus, compare and closing tasks
  // ************************************************************
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // single word transfer; address phase held until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic load(input int i, input logic [7:0] pr, input logic [31:0] w0);
    wr(OFS_TXSEL, 32'(1 << i));
    rchk("select", OFS_TXSEL, 32'(1 << i));
    wr({OFS_TXWIN, 4'h0}, w0);
    wr({OFS_TXWIN, 4'hC}, {16'h0, pr, 8'h08});
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rchk("tx flags", OFS_TXFLG, 32'h7);
    rchk("rx flags", OFS_RXFLG, 32'h0);
    rchk("rx window", {OFS_RXWIN, 4'h0}, 32'h0);
    rchk("unmapped", 8'hFC, 32'h0);
    wr(OFS_TXSEL, 32'h6);
    rchk("select", OFS_TXSEL, 32'h2);
  endtask
  task automatic t_local_priority();
    logic [2:0]  g;
    logic [31:0] w;
    logic [31:0] e = 32'h0;
    logic [7:0]  pr [3] = '{8'h05, 8'h02, 8'h02};
    int          ord [3] = '{1, 2, 0};
    wr(OFS_CTRL, 32'h0E);
    for (int i = 0; i < NUM_TX; i++) load(i, pr[i], 32'hA000 + 32'(i));
    wr(OFS_TXFLG, 32'h7);
    rchk("tx flags", OFS_TXFLG, 32'h0);
    chk("tx irq", 32'h0, 32'(tx_irq));
    for (int k = 0; k < NUM_TX; k++) begin
      u_cmb_can_node.arb(g);
      chk("grant", 32'(4 + ord[k]), 32'(g));
      if (k == 0) begin
        u_cmb_can_node.finish(1, 0, w);
        u_cmb_can_node.arb(g);
        chk("regrant", 32'(4 + ord[k]), 32'(g));
      end
      u_cmb_can_node.finish(0, k * 3, w);
      chk("tx word", 32'hA000 + 32'(ord[k]), w);
      e = e | 32'(1 << ord[k]);
      rchk("tx flags", OFS_TXFLG, e);
      chk("tx irq", 32'h1, 32'(tx_irq));
      wr(OFS_TXSEL, 32'(1 << ord[k]));
      rchk("stamp", {OFS_TXWIN, 4'hC}, {STAMP, pr[ord[k]], 8'h08});
    end
  endtask
  task automatic t_abort();
    logic [2:0]  g;
    logic [31:0] w;
    load(0, 8'h01, 32'hB000);
    load(1, 8'h09, 32'hB001);
    wr(OFS_TXFLG, 32'h3);
    u_cmb_can_node.arb(g);
    chk("grant", 32'h4, 32'(g));
    wr(OFS_ABORT_REQUEST_BIT, 32'h3);
    rchk("abort ack", OFS_ABORT_ACKNOWLEDGE_FLAG, 32'h2);
    rchk("tx flags", OFS_TXFLG, 32'h6);
    u_cmb_can_node.finish(0, 1, w);
    rchk("tx flags", OFS_TXFLG, 32'h7);
    rchk("abort ack", OFS_ABORT_ACKNOWLEDGE_FLAG, 32'h2);
  endtask
  task automatic t_rx();
    wr(OFS_CTRL, 32'h30);
    u_cmb_can_node.frame(32'h0100, 1'b0);
    rchk("rx flags", OFS_RXFLG, 32'h0);
    for (int k = 1; k <= RX_DEPTH; k++) u_cmb_can_node.frame(32'(32'h1000 * k), 1'b1);
    rchk("rx flags", OFS_RXFLG, 32'h1);
    chk("rx irq", 32'h1, 32'(rx_irq));
    u_cmb_can_node.frame(32'hF000, 1'b1);
    rchk("overrun", OFS_RXFLG, 32'h3);
    chk("err irq", 32'h1, 32'(err_irq));
    for (int k = 1; k <= RX_DEPTH + 1; k++) begin
      rchk("rx head", {OFS_RXWIN, 4'h0}, 32'(32'h1000 * k));
      rchk("rx tail", {OFS_RXWIN, 4'hC}, 32'(32'h1000 * k + 3));
      wr(OFS_RXFLG, 32'h1);
      if (k == 1) u_cmb_can_node.frame(32'(32'h1000 * (RX_DEPTH + 1)), 1'b1);
    end
    rchk("rx flags", OFS_RXFLG, 32'h2);
    wr(OFS_RXFLG, 32'h2);
    rchk("rx flags", OFS_RXFLG, 32'h0);
  endtask
  // own frame during a send; kind 2 loses arbitration first
  task automatic own_case(input logic [31:0] ctl, input int kind, input logic ack,
                          input logic [31:0] rx_full_flag);
    logic [2:0]  g;
    logic [31:0] w;
    wr(OFS_CTRL, ctl);
    load(0, 8'h03, 32'hC000);
    wr(OFS_TXFLG, 32'h1);
    u_cmb_can_node.arb(g);
    chk("ack allow", 32'(ack), 32'(rx_ack_allow));
    if (kind == 2) u_cmb_can_node.finish(2, 0, w);
    u_cmb_can_node.frame(32'h7000, 1'b1);
    if (kind == 2) u_cmb_can_node.arb(g);
    u_cmb_can_node.finish(0, 0, w);
    rchk("own frame", OFS_RXFLG, rx_full_flag);
    wr(OFS_RXFLG, 32'h1);
  endtask
  // main sequence after a five cycle reset
  initial begin
    #1 hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_local_priority();
    t_abort();
    t_rx();
    own_case(32'h0, 0, 1'b0, 32'h0);
    own_case(32'h1, 0, 1'b1, 32'h1);
    own_case(32'h0, 2, 1'b0, 32'h1);
    complete_run();
  end
  // watchdog: the run needs far fewer than 50000 cycles
  initial begin
    #1000000;
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire

// ---- test/cmb_can_node.sv ----
// bit engine and bus side model: arbitration, frame ends, received frames
`timescale 1ns/1ps
`default_nettype none
module cmb_can_node #(
  parameter logic [15:0] STAMP = 16'hC3A5
) (
  input  wire logic        hclk,
  input  wire logic        tx_grant_valid,
  input  wire logic [1:0]  tx_grant_index,
  input  wire logic [31:0] tx_word_data,
  output logic             arb_req,
  output logic [1:0]       tx_word_addr,
  output logic             tx_done,
  output logic             tx_error,
  output logic             tx_lost,
  output logic [15:0]      tx_stamp,
  output logic             rx_wr_valid,
  output logic [1:0]       rx_wr_addr,
  output logic [31:0]      rx_wr_data,
  output logic             rx_commit
);
  // quiet bus at time zero
  initial begin
    {arb_req, tx_done, tx_error, tx_lost, rx_wr_valid, rx_commit} = 6'h00;
    tx_word_addr = 2'h3;
    rx_wr_addr = 2'h0;
    rx_wr_data = 32'h0;
    tx_stamp = STAMP;
  end
  // arbitration point, grant read once settled
  task automatic arb(output logic [2:0] g);
    @(posedge hclk);
    arb_req <= 1'b1;
    @(posedge hclk);
    arb_req <= 1'b0;
    @(negedge hclk);
    g = {tx_grant_valid, tx_grant_index};
  endtask
  // kind 0 sent, 1 error, 2 lost; gap models a slow frame
  task automatic finish(input int kind, input int gap, output logic [31:0] w);
    @(posedge hclk);
    tx_word_addr <= 2'h0;
    repeat (gap + 2) @(posedge hclk);
    w = tx_word_data;
    tx_done <= (kind == 0);
    tx_error <= (kind == 1);
    tx_lost <= (kind == 2);
    @(posedge hclk);
    {tx_done, tx_error, tx_lost} <= 3'h0;
    tx_word_addr <= 2'h3;
    repeat (2) @(posedge hclk);
  endtask
  // four words into background, then commit or drop
  task automatic frame(input logic [31:0] base, input logic ok);
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      rx_wr_valid <= 1'b1;
      rx_wr_addr <= 2'(i);
      rx_wr_data <= base + 32'(i);
    end
    @(posedge hclk);
    rx_wr_valid <= 1'b0;
    rx_wr_data <= ~rx_wr_data;  // released lines show no stale word
    rx_commit <= ok;
    @(posedge hclk);
    rx_commit <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ---- test/cmb_checker.sv ----
// port level assertions for the message buffer store
`timescale 1ns/1ps
`default_nettype none
module cmb_checker #(
  parameter int RX_DEPTH = 5
) (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       arb_req,
  input wire logic       tx_grant_valid,
  input wire logic [1:0] tx_grant_index,
  input wire logic       tx_done,
  input wire logic       tx_error,
  input wire logic       tx_lost,
  input wire logic       rx_commit,
  input wire logic       rx_ack_allow,
  input wire logic       tx_irq,
  input wire logic       rx_irq,
  input wire logic       err_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ************************************************************
  // transmit grant
  // ************************************************************
  sequence tx_end_s;
    tx_grant_valid && (tx_done || tx_error || tx_lost);
  endsequence
  sequence tx_busy_s;
    tx_grant_valid && !(tx_done || tx_error || tx_lost);
  endsequence
  grant_cause_a:
    assert property ($rose(tx_grant_valid) |-> $past(arb_req))
    else $error("grant rose without arbitration point");
  grant_end_a:
    assert property (tx_end_s |=> !tx_grant_valid)
    else $error("grant outlived its frame end");
  grant_hold_a:
    assert property (tx_busy_s |=> tx_grant_valid && $stable(tx_grant_index))
    else $error("frame in progress lost its grant");
  index_range_a:
    assert property (tx_grant_valid |-> tx_grant_index <= 2'h2)
    else $error("grant index beyond buffer count");
  ack_idle_a:
    assert property (!tx_grant_valid |-> rx_ack_allow)
    else $error("ack withheld while not sending");
  bus_okay_a:
    assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erred");
  // ************************************************************
  // receive and error interrupts
  // ************************************************************
  rx_rise_a:
    assert property ($rose(rx_irq) |-> $past(rx_commit) || $past(rx_commit, 2)
      || $past(rx_commit, 3) || $past(hsel && htrans[1] && hwrite, 2))
    else $error("rx interrupt rose without a frame");
  rx_clear_a:
    assert property ($fell(rx_irq) |-> $past(hsel && htrans[1] && hwrite, 2))
    else $error("rx interrupt fell without host write");
  ovr_cause_a:
    assert property ($rose(err_irq) |-> $past(rx_commit)
      || $past(hsel && htrans[1] && hwrite, 2))
    else $error("overrun without a dropped frame");
  reset_state_a:
    assert property (disable iff (1'b0) !hresetn |-> !tx_grant_valid && !tx_irq
      && !rx_irq && !err_irq && rx_ack_allow)
    else $error("outputs not at reset values");
endmodule
bind cmb_msg_store cmb_checker #(.RX_DEPTH(RX_DEPTH)) u_cmb_checker (.*);
`default_nettype wire
